// ===== hdl/port_b_digital_io.sv
// Operation
// - Direction one drives output latch level
// - Input with latch one enables pull-up
// - Pull-up off when latch zero or output
// - Reset tri-states every pin immediately
// - Internal oscillator fuse frees pin three
// - Programming mode takes pin two as clock
// - Pin two clocks timer even as output
// - Programming mode drives pin one as data
// - Pin one feeds interrupt even as output
// - Programming mode takes pin zero as data
// - Latch reads stored, readback reads pins
`timescale 1ns/100ps
`default_nettype none
`include "port_io_cfg.svh"

module port_b_digital_io (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Pins, split into level in, drive out, active-low enable and pull-up enable.
    input  wire logic [4:0]  port_pin_in,
    output logic      [4:0]  port_pin_out,
    output logic      [4:0]  port_pin_oe_n,
    output logic      [4:0]  pin_pullup_en,
    // Fuse level and programmer data.
    input  wire logic        internal_osc_select_fuse,
    input  wire logic        prog_miso_data,
    // Alternate function taps.
    output logic             timer_external_clock_in,
    output logic             external_interrupt_zero_in,
    output logic             prog_sck_in,
    output logic             prog_mosi_in,
    output logic             ext_clock_in,
    output logic             prog_mode
);

    // Software state.
    port_io_pkg::port_vec_t  direction_register;
    port_io_pkg::port_vec_t  output_latch_register;
    logic [1:0]              alt_control;
    port_io_pkg::port_vec_t  next_direction_register;
    port_io_pkg::port_vec_t  next_output_latch_register;
    logic [1:0]              next_alt_control;
    // Bus phase state.
    port_io_pkg::bus_state_t bus_state;
    port_io_pkg::bus_state_t next_bus_state;
    logic [11:0]             wr_addr;
    logic [11:0]             next_wr_addr;
    logic                    wr_pend;
    logic                    next_wr_pend;
    logic [31:0]             next_hrdata;
    // Pin synchronisers; stage one is read only by stage two.
    port_io_pkg::port_vec_t  pin_meta;
    port_io_pkg::port_vec_t  pin_sync;
    logic                    fuse_meta;
    logic                    fuse_sync;
    logic                    fuse_latched;
    logic                    fuse_taken;
    // Pin drive next values.
    port_io_pkg::port_vec_t  next_pin_out;
    port_io_pkg::port_vec_t  next_pin_oe_n;
    port_io_pkg::port_vec_t  next_pullup;
    logic                    pin3_is_io;

    // Two-flop synchronisers for pins and fuse level.
    always_ff @(posedge clock) begin
        pin_meta  <= port_pin_in;
        pin_sync  <= pin_meta;
        fuse_meta <= internal_osc_select_fuse;
        fuse_sync <= fuse_meta;
    end

    // The fuse takes effect only at reset, so it is caught after release.
    // fuse after reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fuse_taken   <= 1'b0;
            fuse_latched <= 1'b0;
        end else if (!fuse_taken) begin
            fuse_taken   <= 1'b1;
            fuse_latched <= fuse_sync;
        end
    end

    // Fuse programmed (low) selects internal RC; pin three is then I/O.
    // pin three io
    assign pin3_is_io = fuse_taken && !fuse_latched;

    // Bus decode and register next values.
    always_comb begin
        next_direction_register    = direction_register;
        next_output_latch_register = output_latch_register;
        next_alt_control           = alt_control;
        next_bus_state             = port_io_pkg::bus_idle;
        next_wr_addr               = wr_addr;
        next_wr_pend               = 1'b0;
        next_hrdata                = hrdata;
        // Write data phase: commit hwdata to the address latched in the address phase.
        if (bus_state == port_io_pkg::bus_data && wr_pend) begin
            unique case (wr_addr)
                `DIRECTION_REGISTER_OFS: begin
                    next_direction_register = hwdata[4:0];
                end
                `OUTPUT_LATCH_REGISTER_OFS: begin
                    next_output_latch_register = hwdata[4:0];
                end
                `ALT_CONTROL_OFS: begin
                    next_alt_control = hwdata[1:0];
                end
                default: begin
                    // Readback and unmapped addresses ignore writes.
                end
            endcase
        end
        // Address phase taken when selected and bus ready.
        if (hsel && hready && htrans[1]) begin
            next_bus_state = port_io_pkg::bus_data;
            next_wr_addr   = haddr[11:0];
            next_wr_pend   = hwrite;
            next_hrdata    = 32'h0000_0000;
            if (!hwrite) begin
                unique case (haddr[11:0])
                    `DIRECTION_REGISTER_OFS: begin
                        next_hrdata[4:0] = direction_register;
                    end
                    `OUTPUT_LATCH_REGISTER_OFS: begin
                        next_hrdata[4:0] = output_latch_register;
                    end
                    `PIN_LEVEL_READBACK_OFS: begin
                        next_hrdata[4:0] = pin_sync;
                    end
                    `ALT_CONTROL_OFS: begin
                        next_hrdata[1:0] = alt_control;
                    end
                    default: begin
                        // Unmapped reads return zero.
                    end
                endcase
            end
        end
    end

    // Register update; reset clears all control state.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            direction_register    <= `DIRECTION_RESET;
            output_latch_register <= `OUTPUT_LATCH_RESET;
            alt_control           <= `ALT_CONTROL_RESET;
            bus_state             <= port_io_pkg::bus_idle;
            wr_addr               <= 12'h000;
            wr_pend               <= 1'b0;
            hrdata                <= 32'h0000_0000;
        end else begin
            direction_register    <= next_direction_register;
            output_latch_register <= next_output_latch_register;
            alt_control           <= next_alt_control;
            bus_state             <= next_bus_state;
            wr_addr               <= next_wr_addr;
            wr_pend               <= next_wr_pend;
            hrdata                <= next_hrdata;
        end
    end

    // Zero-wait slave: always ready, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Pin drive computation from direction, latch and alternate modes.
    always_comb begin
        next_pin_out  = output_latch_register;
        next_pin_oe_n = ~direction_register;
        next_pullup   = ~direction_register & output_latch_register;
        // Pin three given up to the external clock when fuse unprogrammed.
        if (!pin3_is_io) begin
            next_pin_oe_n[`PIN_CLOCK] = 1'b1;
            next_pullup[`PIN_CLOCK]   = 1'b0;
        end
        if (alt_control[`ALT_PROG_MODE_BIT]) begin
            next_pin_out[`PIN_MISO]  = prog_miso_data;
            next_pin_oe_n[`PIN_MISO] = 1'b0;
            next_pullup[`PIN_MISO]   = 1'b0;
            next_pin_oe_n[`PIN_SCK]  = 1'b1;
            next_pin_oe_n[`PIN_MOSI] = 1'b1;
            next_pullup[`PIN_SCK]    = 1'b0;
            next_pullup[`PIN_MOSI]   = 1'b0;
        end
    end

    // Pin drive registers; reset lets the pins go at once, clock or not.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            port_pin_out  <= 5'h00;
            port_pin_oe_n <= 5'h1f;
            pin_pullup_en <= 5'h00;
        end else begin
            port_pin_out  <= next_pin_out;
            port_pin_oe_n <= next_pin_oe_n;
            pin_pullup_en <= next_pullup;
        end
    end

    // Alternate taps read the synchronised pin level, whatever the direction.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timer_external_clock_in    <= 1'b0;
            external_interrupt_zero_in <= 1'b0;
            prog_sck_in                <= 1'b0;
            prog_mosi_in               <= 1'b0;
            ext_clock_in               <= 1'b0;
            prog_mode                  <= 1'b0;
        end else begin
            timer_external_clock_in <= !alt_control[`ALT_PROG_MODE_BIT]
                && alt_control[`ALT_TIMER_EXT_BIT] && pin_sync[`PIN_SCK];
            external_interrupt_zero_in <= !alt_control[`ALT_PROG_MODE_BIT]
                && pin_sync[`PIN_MISO];
            prog_sck_in  <= alt_control[`ALT_PROG_MODE_BIT]
                && pin_sync[`PIN_SCK];
            prog_mosi_in <= alt_control[`ALT_PROG_MODE_BIT]
                && pin_sync[`PIN_MOSI];
            ext_clock_in <= !pin3_is_io && pin_sync[`PIN_CLOCK];
            prog_mode    <= alt_control[`ALT_PROG_MODE_BIT];
        end
    end

    // Assertions.
    a_reset_tristate: assert property (@(posedge clock)
        sys_rst |=> port_pin_oe_n == 5'h1f && pin_pullup_en == 5'h00)
        else $error("pins not tri-stated after reset");

    a_output_level: assert property (
        @(posedge clock) disable iff (sys_rst)
        (direction_register[4] && !$past(sys_rst))
        |=> port_pin_oe_n[4] == 1'b0
            && port_pin_out[4] == $past(output_latch_register[4]))
        else $error("output pin not driving latch level");

    a_pullup_input: assert property (
        @(posedge clock) disable iff (sys_rst)
        (!direction_register[0] && output_latch_register[0]
         && !alt_control[0]) |=> pin_pullup_en[0])
        else $error("pull-up missing on input");

    a_pullup_off: assert property (
        @(posedge clock) disable iff (sys_rst)
        (direction_register[4] || !output_latch_register[4])
        |=> !pin_pullup_en[4])
        else $error("pull-up active when forbidden");

    a_pin3_io: assert property (
        @(posedge clock) disable iff (sys_rst)
        (pin3_is_io && direction_register[3]) |=> !port_pin_oe_n[3])
        else $error("pin three not usable as io");

    a_miso_drive: assert property (
        @(posedge clock) disable iff (sys_rst)
        alt_control[0] |=> !port_pin_oe_n[1]
            && port_pin_out[1] == $past(prog_miso_data))
        else $error("programmer data not driven");

    a_timer_tap: assert property (
        @(posedge clock) disable iff (sys_rst)
        (alt_control == 2'h2) |=> timer_external_clock_in
            == $past(pin_sync[2]))
        else $error("timer clock tap wrong");

    a_int_tap: assert property (
        @(posedge clock) disable iff (sys_rst)
        (!alt_control[0] && direction_register[1])
        |=> external_interrupt_zero_in == $past(pin_sync[1]))
        else $error("interrupt tap blocked by output");

    a_reset_clear: assert property (@(posedge clock)
        sys_rst |=> direction_register == 5'h00
            && output_latch_register == 5'h00)
        else $error("control bits not cleared by reset");

endmodule
`default_nettype wire

// ===== hdl/port_io_cfg.svh
`ifndef PORT_IO_CFG_SVH
`define PORT_IO_CFG_SVH
// Register byte offsets on the bus.
`define DIRECTION_REGISTER_OFS     12'h000
`define OUTPUT_LATCH_REGISTER_OFS  12'h004
`define PIN_LEVEL_READBACK_OFS     12'h008
`define ALT_CONTROL_OFS            12'h00c
// Reset values.
`define DIRECTION_RESET            5'h00
`define OUTPUT_LATCH_RESET         5'h00
`define ALT_CONTROL_RESET          2'h0
// Alternate control field positions.
`define ALT_PROG_MODE_BIT          0
`define ALT_TIMER_EXT_BIT          1
// Pin positions of alternate functions.
`define PIN_MOSI                   0
`define PIN_MISO                   1
`define PIN_SCK                    2
`define PIN_CLOCK                  3
`endif

// ===== hdl/port_io_pkg.sv
package port_io_pkg;
    // Five-pin port vector.
    typedef logic [4:0] port_vec_t;
    // Bus data phase states of the slave.
    typedef enum logic [0:0] {
        bus_idle,
        bus_data
    } bus_state_t;
endpackage

// ===== bench/board_model.sv
`timescale 1ns/100ps
`default_nettype none

// Board and programmer beside the port; resolves the level on each pin.
module board_model (
    input  wire logic       clock,
    input  wire logic [4:0] port_pin_out,
    input  wire logic [4:0] port_pin_oe_n,
    input  wire logic [4:0] pin_pullup_en,
    input  wire logic [4:0] ext_val,
    input  wire logic [4:0] ext_en,
    output logic      [4:0] port_pin_in
);
    logic [4:0] float_pat = 5'h0a; // Undriven pins wander every cycle.

    // A floating line must never look like a held level.
    always @(posedge clock) begin
        float_pat <= ~float_pat;
    end

    // The port wins, then outside drivers, then the pull-up.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (!port_pin_oe_n[i]) begin
                port_pin_in[i] = port_pin_out[i];
            end else if (ext_en[i]) begin
                port_pin_in[i] = ext_val[i];
            end else if (pin_pullup_en[i]) begin
                port_pin_in[i] = 1'b1;
            end else begin
                port_pin_in[i] = float_pat[i];
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_io_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    miscompares++; $display("[ERR] %0t %h %h", $time, (a), (e)); end end

module testbench;
    logic        clock   = 1'b0;  // Bench clock.
    logic        sys_rst = 1'b1;  // Reset request.
    logic        hsel    = 1'b0;  // Bus select.
    logic [31:0] haddr   = 32'h0; // Bus address.
    logic [1:0]  htrans  = 2'h0;  // Transfer kind.
    logic        hwrite  = 1'b0;  // Write flag.
    logic [31:0] hwdata  = 32'h0; // Write data.
    logic        fuse    = 1'b0;  // Oscillator fuse level.
    logic        miso    = 1'b0;  // Programmer data out.
    logic [4:0]  ext_val = 5'h00; // Outside drive level.
    logic [4:0]  ext_en  = 5'h00; // Outside drive enable.
    logic        rd_dph  = 1'b0;  // Read data phase open.
    logic [31:0] hrdata, exp_w, r;
    logic        hreadyout, hresp, tmr, irq, sck, mosi, extclk, pmode;
    logic [4:0]  pin_in, pin_out, oe_n, pull, d, l, v, lvl;
    logic [1:0]  alt;
    logic [31:0] q[$];            // Expected read words.
    int          seed = 8;
    int          cyc = 0;
    int          miscompares = 0;
    int          total_checks = 0;

    port_b_digital_io i_dut (.clock(clock), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_pin_in(pin_in), .port_pin_out(pin_out),
        .port_pin_oe_n(oe_n), .pin_pullup_en(pull),
        .internal_osc_select_fuse(fuse), .prog_miso_data(miso),
        .timer_external_clock_in(tmr),
        .external_interrupt_zero_in(irq), .prog_sck_in(sck),
        .prog_mosi_in(mosi), .ext_clock_in(extclk), .prog_mode(pmode));

    board_model i_board (.clock(clock), .port_pin_out(pin_out),
        .port_pin_oe_n(oe_n), .pin_pullup_en(pull), .ext_val(ext_val),
        .ext_en(ext_en), .port_pin_in(pin_in));

    // Free running 200 MHz clock.
    always #2.5 clock = ~clock;

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One single word transfer; a read notes its expected word.
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] dw);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        if (!wr) begin
            q.push_back(dw);
        end
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wr ? dw : 32'h0;
        rd_dph <= !wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd_dph <= 1'b0;
    endtask

    // Lets pin changes pass the synchroniser and the tap registers.
    task automatic settle();
        repeat (5) @(posedge clock);
        #1;
    endtask

    // Compares read data at the closing edge; also cuts a hang short.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (rd_dph === 1'b1 && hreadyout === 1'b1) begin
            exp_w = q.pop_front();
            `CHK(hrdata, exp_w)
            `CHK(hresp, 1'b0)
        end
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        `CHK(oe_n, 5'h1f)
        `CHK(pull, 5'h00)
        settle();
        xfer(1'b0, `DIRECTION_REGISTER_OFS, 32'h0);
        xfer(1'b0, `OUTPUT_LATCH_REGISTER_OFS, 32'h0);
        // First pass covers all four direction and latch pairings.
        for (int k = 0; k < 7; k++) begin
            r = $random(seed);
            d = (k == 0) ? 5'h0c : r[4:0];
            l = (k == 0) ? 5'h0a : r[9:5];
            v = r[14:10];
            alt = {r[15], 1'b0};
            ext_en <= ~d;
            ext_val <= v;
            xfer(1'b1, `ALT_CONTROL_OFS, {30'h0, alt});
            xfer(1'b1, `DIRECTION_REGISTER_OFS, {27'h0, d});
            xfer(1'b1, `OUTPUT_LATCH_REGISTER_OFS, {27'h0, l});
            settle();
            lvl = (l & d) | (v & ~d);
            `CHK(oe_n, ~d)
            `CHK(pin_out & d, l & d)
            `CHK(pull, l & ~d)
            `CHK(irq, lvl[1])
            `CHK(tmr, alt[1] & lvl[2])
            xfer(1'b0, `OUTPUT_LATCH_REGISTER_OFS, {27'h0, l});
            xfer(1'b0, `PIN_LEVEL_READBACK_OFS, {27'h0, lvl});
        end
        // Programming mode takes over pins zero to two; timer select is
        // set as well and must stay masked, as must the interrupt tap.
        ext_en <= 5'h05;
        xfer(1'b1, `ALT_CONTROL_OFS, 32'h3);
        for (int b = 0; b < 2; b++) begin
            miso <= b[0];
            ext_val <= {5{~b[0]}};
            settle();
            `CHK(oe_n[2:0], 3'h5)
            `CHK(tmr, 1'b0)
            `CHK(irq, 1'b0)
            `CHK(pin_out[1], b[0])
            `CHK(sck, ~b[0])
            `CHK(mosi, ~b[0])
            `CHK(pmode, 1'b1)
        end
        // An unmapped write leaves everything alone and reads zero.
        xfer(1'b1, 12'h010, 32'h1f);
        xfer(1'b0, 12'h010, 32'h0);
        xfer(1'b0, `ALT_CONTROL_OFS, 32'h3);
        // Reset in mid run with the fuse left unprogrammed.
        fuse <= 1'b1;
        sys_rst <= 1'b1;
        // Pins must let go before any clock edge sees the reset.
        #1;
        `CHK(oe_n, 5'h1f)
        @(posedge clock);
        #1;
        `CHK(oe_n, 5'h1f)
        `CHK(pull, 5'h00)
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        settle();
        ext_en <= 5'h08;
        xfer(1'b1, `DIRECTION_REGISTER_OFS, 32'h1f);
        xfer(1'b1, `OUTPUT_LATCH_REGISTER_OFS, 32'h08);
        for (int b = 0; b < 2; b++) begin
            ext_val <= {5{b[0]}};
            settle();
            `CHK(oe_n[3], 1'b1)
            `CHK(pull[3], 1'b0)
            `CHK(extclk, b[0])
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
